//--- logic/cmpo_pkg.sv
// constants shared by the comparator output logic: register map, field positions,
// reset values, input select codes and filter timing.
// assumes a 20 MHz core clock and an 8-bit register port.
package cmpo_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PORT_W = 8;
    localparam int TMR_W = 16;
    localparam int SEL_W = 3;

    localparam logic [ADDR_W-1:0] REG_CTRL_A = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL_B = 4'h1;
    localparam logic [ADDR_W-1:0] REG_FLAG = 4'h2;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN = 4'h3;
    localparam logic [ADDR_W-1:0] REG_ANALOG_SELECT_REG = 4'h4;
    localparam logic [ADDR_W-1:0] REG_DIR = 4'h5;
    localparam logic [ADDR_W-1:0] REG_PORT = 4'h6;
    localparam logic [ADDR_W-1:0] REG_TMR_CTL = 4'h7;
    localparam logic [ADDR_W-1:0] REG_TMR_LO = 4'h8;
    localparam logic [ADDR_W-1:0] REG_TMR_HI = 4'h9;

    // control_a fields
    localparam int CA_ON = 7;
    localparam int CA_OUT = 6;
    localparam int CA_POL = 4;
    localparam int CA_ZLF = 3;
    localparam int CA_SP = 2;
    localparam int CA_HYS = 1;
    localparam int CA_SYNC = 0;
    localparam logic [DATA_W-1:0] CA_WR_MASK = 8'hbf;
    localparam logic [DATA_W-1:0] CA_RESET = 8'h04;

    // control_b fields
    localparam int CB_INTP = 7;
    localparam int CB_INTN = 6;
    localparam int CB_NCH_LSB = 3;
    localparam int CB_PCH_LSB = 0;
    localparam logic [DATA_W-1:0] CB_RESET = 8'h00;

    localparam int FLAG_BIT = 0;
    localparam int TC_ON = 0;
    localparam int TC_GATE = 1;
    localparam int TC_PRESC = 2;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONES_BYTE = 8'hff;

    // plus input select codes
    localparam logic [SEL_W-1:0] PCH_PIN = 3'h0;
    localparam logic [SEL_W-1:0] PCH_DAC = 3'h1;
    localparam logic [SEL_W-1:0] PCH_FREF = 3'h2;
    localparam logic [SEL_W-1:0] PCH_GND = 3'h3;
    // minus input select codes; pin one is shared with the op-amp output
    localparam logic [SEL_W-1:0] NCH_PIN0 = 3'h0;
    localparam logic [SEL_W-1:0] NCH_PIN1 = 3'h1;
    localparam logic [SEL_W-1:0] NCH_FREF = 3'h2;
    localparam logic [SEL_W-1:0] NCH_AGND = 3'h3;
    localparam logic [SEL_W-1:0] SEL_NONE = 3'h0;

    localparam int CLK_PERIOD_NS = 50;
    localparam int FILTER_NS = 20;
    localparam int FILTER_CYC_RAW = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_CYC = (FILTER_CYC_RAW < 1) ? 1 : FILTER_CYC_RAW;
endpackage : cmpo_pkg

//--- logic/cmpo_filter.sv
// zero-latency glitch filter: passes a transition at once, then holds it.
// assumes d is already synchronous to core_clk.
`timescale 1ns/10ps
module cmpo_filter #(
    parameter int HOLD = cmpo_pkg::FILTER_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic en,
    input wire logic d,
    output logic q_r
);
    import cmpo_pkg::*;

    localparam int CNT_W = $clog2(HOLD + 1);
    localparam logic [CNT_W-1:0] HOLD_C = CNT_W'(HOLD);

    logic [CNT_W-1:0] hold_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q_r <= 1'b0;
            hold_r <= '0;
        end else if (!en) begin
            q_r <= d;
            hold_r <= '0;
        end else if (hold_r != '0) begin
            // a reversal during the hold waits for the hold to end; one gone by then is dropped
            hold_r <= hold_r - 1'b1;
        end else if (d != q_r) begin
            q_r <= d;
            hold_r <= HOLD_C;
        end
    end

    AST_FILTER_HOLD: assert property (@(posedge core_clk) disable iff (srst)
        en && $past(en) && $changed(q_r) && !$past(srst) |=> $stable(q_r))
        else $error("filter output reversed inside hold time");
endmodule : cmpo_filter

//--- logic/cmpo_top.sv
// comparator output logic: polarity, glitch filter, timer-clock sync, gate timer,
// edge interrupt flag, input select steering and port read masking.
// assumes the analog result and timer clock pins are asynchronous to core_clk.
//
// What this block does
// - output is plus-above-minus, complemented when output_invert is set
// - speed_select resets to one (normal speed), zero selects low power
// - hysteresis_enable drives the analog hysteresis control
// - result offered as gate source of the gate timer
// - with timer_sync_enable, latch result on timer clock falling edge
// - with prescaler in use, latch on the prescaled clock instead
// - gate timer counts only on the rising edge of its clock
// - enabled rising or falling output edge sets compare_irq_flag
// - software clears the flag; a same-cycle edge keeps it set
// - toggling invert or enable moves the output and may fire edges
// - plus_input_select routes pin, DAC, fixed_reference or ground
// - comparator off disconnects all inputs regardless of selects
// - minus_input_select routes pins, fixed_reference or analog ground
// - shared pin with enabled op-amp feeds op-amp output to minus input
// - glitch filter blocks a reversal for one 50 ns clock cycle (20 ns rounded up) after a transition
// - port read returns zero for pins selected as analog
// - internal output and pin output both registered each instruction cycle
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module cmpo_top #(
    parameter int TMR_WIDTH = cmpo_pkg::TMR_W
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [cmpo_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cmpo_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cmpo_pkg::DATA_W-1:0] reg_rdata_r,
    input wire logic analog_compare,
    input wire logic tmr_src_clk,
    input wire logic tmr_presc_clk,
    input wire logic opamp_enabled,
    input wire logic [cmpo_pkg::PORT_W-1:0] port_pins,
    output logic cmp_pin_out_r,
    output logic cmp_gate_r,
    output logic compare_irq_r,
    output logic speed_select_r,
    output logic hysteresis_enable_r,
    output logic inputs_connect_r,
    output logic [cmpo_pkg::SEL_W-1:0] plus_route_r,
    output logic [cmpo_pkg::SEL_W-1:0] minus_route_r,
    output logic minus_from_opamp_r,
    output logic [cmpo_pkg::PORT_W-1:0] dir_r
);
    import cmpo_pkg::*;

    logic [DATA_W-1:0] ctrl_a_r;
    logic [DATA_W-1:0] ctrl_b_r;
    logic [PORT_W-1:0] analog_select_reg_r;
    logic [DATA_W-1:0] tmr_ctl_r;
    logic irq_en_r;
    logic flag_r;
    logic [TMR_WIDTH-1:0] tmr_cnt_r;

    // three-stage synchronisers; only stages two and three are looked at
    logic [2:0] cmp_sync_r;
    logic [2:0] tsrc_sync_r;
    logic [2:0] tpre_sync_r;
    logic [PORT_W-1:0] port_s1_r;
    logic [PORT_W-1:0] port_s2_r;
    logic [PORT_W-1:0] port_s3_r;
    logic [PORT_W-1:0] port_stable_r;
    logic cmp_stable_r;
    logic tsrc_stable_r;
    logic tpre_stable_r;

    logic sync_latch_r;
    logic output_state_r;
    logic prev_state_r;

    logic comp_on;
    logic presc_used;
    logic tclk_level;
    logic tclk_agree;
    logic tclk_prev;
    logic tclk_fall;
    logic tclk_rise;
    logic cmp_level;
    logic pol_level;
    logic filt_q;
    logic sync_sel;
    logic rise_evt;
    logic fall_evt;
    logic set_flag;
    logic clr_flag;

    function automatic logic agreed(input logic [2:0] s, input logic old);
        return (s[1] == s[2]) ? s[1] : old;
    endfunction : agreed

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction : hit

    assign comp_on = ctrl_a_r[CA_ON];
    assign presc_used = tmr_ctl_r[TC_PRESC];

    // register writes
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_a_r <= CA_RESET;
            ctrl_b_r <= CB_RESET;
            analog_select_reg_r <= ONES_BYTE;
            dir_r <= ONES_BYTE;
            irq_en_r <= 1'b0;
            tmr_ctl_r <= ZERO_BYTE;
        end else if (reg_wr) begin
            if (hit(reg_addr, REG_CTRL_A)) begin
                ctrl_a_r <= reg_wdata & CA_WR_MASK;
            end
            if (hit(reg_addr, REG_CTRL_B)) begin
                ctrl_b_r <= reg_wdata;
            end
            if (hit(reg_addr, REG_ANALOG_SELECT_REG)) begin
                analog_select_reg_r <= reg_wdata;
            end
            if (hit(reg_addr, REG_DIR)) begin
                dir_r <= reg_wdata;
            end
            if (hit(reg_addr, REG_IRQ_EN)) begin
                irq_en_r <= reg_wdata[FLAG_BIT];
            end
            if (hit(reg_addr, REG_TMR_CTL)) begin
                tmr_ctl_r <= reg_wdata;
            end
        end
    end

    // register reads, data one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata_r <= ZERO_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL_A: begin
                    reg_rdata_r <= (ctrl_a_r & CA_WR_MASK) | (DATA_W'(output_state_r) << CA_OUT);
                end
                REG_CTRL_B: reg_rdata_r <= ctrl_b_r;
                REG_FLAG: reg_rdata_r <= DATA_W'(flag_r);
                REG_IRQ_EN: reg_rdata_r <= DATA_W'(irq_en_r);
                REG_ANALOG_SELECT_REG: reg_rdata_r <= analog_select_reg_r;
                REG_DIR: reg_rdata_r <= dir_r;
                REG_PORT: reg_rdata_r <= port_stable_r & ~analog_select_reg_r;
                REG_TMR_CTL: reg_rdata_r <= tmr_ctl_r;
                REG_TMR_LO: reg_rdata_r <= tmr_cnt_r[DATA_W-1:0];
                REG_TMR_HI: reg_rdata_r <= tmr_cnt_r[TMR_WIDTH-1:TMR_WIDTH-DATA_W];
                default: reg_rdata_r <= ZERO_BYTE;
            endcase
        end else begin
            reg_rdata_r <= ZERO_BYTE;
        end
    end

    // pin synchronisers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmp_sync_r <= 3'h0;
            tsrc_sync_r <= 3'h0;
            tpre_sync_r <= 3'h0;
            cmp_stable_r <= 1'b0;
            tsrc_stable_r <= 1'b0;
            tpre_stable_r <= 1'b0;
        end else begin
            cmp_sync_r <= {cmp_sync_r[1:0], analog_compare};
            tsrc_sync_r <= {tsrc_sync_r[1:0], tmr_src_clk};
            tpre_sync_r <= {tpre_sync_r[1:0], tmr_presc_clk};
            cmp_stable_r <= agreed(cmp_sync_r, cmp_stable_r);
            tsrc_stable_r <= agreed(tsrc_sync_r, tsrc_stable_r);
            tpre_stable_r <= agreed(tpre_sync_r, tpre_stable_r);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            port_s1_r <= ZERO_BYTE;
            port_s2_r <= ZERO_BYTE;
            port_s3_r <= ZERO_BYTE;
            port_stable_r <= ZERO_BYTE;
        end else begin
            port_s1_r <= port_pins;
            port_s2_r <= port_s1_r;
            port_s3_r <= port_s2_r;
            for (int i = 0; i < PORT_W; i++) begin
                if (port_s2_r[i] == port_s3_r[i]) begin
                    port_stable_r[i] <= port_s2_r[i];
                end
            end
        end
    end

    // timer clock edge: prescaled clock when the prescaler is used
    always_comb begin
        if (presc_used) begin
            tclk_level = tpre_sync_r[1];
            tclk_agree = tpre_sync_r[1] == tpre_sync_r[2];
            tclk_prev = tpre_stable_r;
        end else begin
            tclk_level = tsrc_sync_r[1];
            tclk_agree = tsrc_sync_r[1] == tsrc_sync_r[2];
            tclk_prev = tsrc_stable_r;
        end
    end
    assign tclk_fall = tclk_agree && tclk_prev && !tclk_level;
    assign tclk_rise = tclk_agree && !tclk_prev && tclk_level;

    // comparator off forces the result low before polarity, so toggling moves it
    assign cmp_level = comp_on & cmp_stable_r;
    assign pol_level = cmp_level ^ ctrl_a_r[CA_POL];

    cmpo_filter #(
        .HOLD(FILTER_CYC)
    ) u_filter (
        .core_clk(core_clk),
        .srst(srst),
        .en(ctrl_a_r[CA_ZLF]),
        .d(pol_level),
        .q_r(filt_q)
    );

    // latch on the timer clock falling edge, opposite to the count edge
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync_latch_r <= 1'b0;
        end else if (tclk_fall) begin
            sync_latch_r <= filt_q;
        end
    end
    assign sync_sel = ctrl_a_r[CA_SYNC] ? sync_latch_r : filt_q;

    // registered once per cycle for internal users and the pin output
    always_ff @(posedge core_clk) begin
        if (srst) begin
            output_state_r <= 1'b0;
            prev_state_r <= 1'b0;
            cmp_pin_out_r <= 1'b0;
            cmp_gate_r <= 1'b0;
        end else begin
            output_state_r <= sync_sel;
            prev_state_r <= output_state_r;
            cmp_pin_out_r <= sync_sel & comp_on;
            cmp_gate_r <= sync_sel;
        end
    end

    // gate timer: counts on rising edges while its gate allows
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tmr_cnt_r <= '0;
        end else if (reg_wr && hit(reg_addr, REG_TMR_LO)) begin
            tmr_cnt_r <= '0;
        end else if (tmr_ctl_r[TC_ON] && tclk_rise && (!tmr_ctl_r[TC_GATE] || cmp_gate_r)) begin
            tmr_cnt_r <= tmr_cnt_r + 1'b1;
        end
    end

    // edge detectors and sticky flag; set beats clear
    assign rise_evt = output_state_r && !prev_state_r && ctrl_b_r[CB_INTP];
    assign fall_evt = !output_state_r && prev_state_r && ctrl_b_r[CB_INTN];
    assign set_flag = rise_evt || fall_evt;
    assign clr_flag = reg_wr && hit(reg_addr, REG_FLAG) && reg_wdata[FLAG_BIT];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flag_r <= 1'b0;
            compare_irq_r <= 1'b0;
        end else begin
            if (set_flag) begin
                flag_r <= 1'b1;
            end else if (clr_flag) begin
                flag_r <= 1'b0;
            end
            // irq_en_r gates the request here; the global enable lives in the interrupt controller
            compare_irq_r <= flag_r && irq_en_r;
        end
    end

    // analog controls and input routing
    always_ff @(posedge core_clk) begin
        if (srst) begin
            speed_select_r <= 1'b1;
            hysteresis_enable_r <= 1'b0;
            inputs_connect_r <= 1'b0;
            plus_route_r <= SEL_NONE;
            minus_route_r <= SEL_NONE;
            minus_from_opamp_r <= 1'b0;
        end else begin
            speed_select_r <= ctrl_a_r[CA_SP];
            hysteresis_enable_r <= ctrl_a_r[CA_HYS];
            inputs_connect_r <= comp_on;
            plus_route_r <= comp_on ? ctrl_b_r[CB_PCH_LSB +: SEL_W] : SEL_NONE;
            minus_route_r <= comp_on ? ctrl_b_r[CB_NCH_LSB +: SEL_W] : SEL_NONE;
            minus_from_opamp_r <= comp_on && opamp_enabled
                && ctrl_b_r[CB_NCH_LSB +: SEL_W] == NCH_PIN1;
        end
    end

    AST_POLARITY: assert property (@(posedge core_clk) disable iff (srst)
        !ctrl_a_r[CA_ZLF] && !ctrl_a_r[CA_SYNC] ##1 !ctrl_a_r[CA_ZLF] && !ctrl_a_r[CA_SYNC]
        |=> output_state_r == ($past(cmp_level, 2) ^ $past(ctrl_a_r[CA_POL], 2)))
        else $error("output state does not follow polarity");
    AST_SPEED: assert property (@(posedge core_clk) disable iff (srst)
        speed_select_r == $past(ctrl_a_r[CA_SP]))
        else $error("speed select not driven from control");
    AST_HYST: assert property (@(posedge core_clk) disable iff (srst)
        reg_wr && hit(reg_addr, REG_CTRL_A) |=> ##1 hysteresis_enable_r == $past(reg_wdata[CA_HYS], 2))
        else $error("hysteresis control not applied");
    AST_SYNC_HOLD: assert property (@(posedge core_clk) disable iff (srst)
        ctrl_a_r[CA_SYNC] && !tclk_fall |=> $stable(sync_latch_r))
        else $error("sync latch moved without a timer clock fall");
    AST_TMR_RISE: assert property (@(posedge core_clk) disable iff (srst)
        !tclk_rise && !(reg_wr && hit(reg_addr, REG_TMR_LO)) |=> $stable(tmr_cnt_r))
        else $error("gate timer counted off its rising edge");
    AST_EDGE_SET: assert property (@(posedge core_clk) disable iff (srst)
        $rose(output_state_r) && ctrl_b_r[CB_INTP] |=> flag_r ##1 compare_irq_r == $past(irq_en_r))
        else $error("rising edge did not raise the flag");
    AST_SET_WINS: assert property (@(posedge core_clk) disable iff (srst)
        set_flag && clr_flag |=> flag_r)
        else $error("flag lost when edge met clear");
    AST_OFF_DISCONNECT: assert property (@(posedge core_clk) disable iff (srst)
        !comp_on |=> !inputs_connect_r && plus_route_r == SEL_NONE && minus_route_r == SEL_NONE)
        else $error("inputs left connected while off");
    AST_OPAMP: assert property (@(posedge core_clk) disable iff (srst)
        minus_from_opamp_r |-> $past(opamp_enabled) && minus_route_r == NCH_PIN1)
        else $error("op-amp steering without its conditions");
    AST_PORT_ANALOG: assert property (@(posedge core_clk) disable iff (srst)
        reg_rd && reg_addr == REG_PORT |=> (reg_rdata_r & $past(analog_select_reg_r)) == ZERO_BYTE)
        else $error("analog pin read as nonzero");

    COV_RISE_IRQ: cover property (@(posedge core_clk) disable iff (srst) rise_evt ##1 flag_r);
    COV_FALL_IRQ: cover property (@(posedge core_clk) disable iff (srst) fall_evt ##1 flag_r);
    COV_SYNC_LATCH: cover property (@(posedge core_clk) disable iff (srst)
        ctrl_a_r[CA_SYNC] && tclk_fall ##1 $changed(sync_latch_r));
    COV_SET_CLEAR: cover property (@(posedge core_clk) disable iff (srst) set_flag && clr_flag);
endmodule : cmpo_top

//--- sim/tb.sv
// self-checking bench for the comparator output logic, driven through the register port.
// assumes the package constants and the one-cycle read latency of the port.
`timescale 1ns/10ps
module tb;
    import cmpo_pkg::*;
    logic core_clk;
    logic srst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata_r;
    logic analog_compare;
    logic tmr_src_clk;
    logic tmr_presc_clk;
    logic opamp_enabled;
    logic [PORT_W-1:0] port_pins;
    logic cmp_pin_out_r;
    logic cmp_gate_r;
    logic compare_irq_r;
    logic speed_select_r;
    logic hysteresis_enable_r;
    logic inputs_connect_r;
    logic [SEL_W-1:0] plus_route_r;
    logic [SEL_W-1:0] minus_route_r;
    logic minus_from_opamp_r;
    logic [PORT_W-1:0] dir_r;
    int error_cnt = 0;
    int checks_done = 0;
    logic [DATA_W-1:0] rd;
    int lat;

    cmpo_top DUT (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .analog_compare(analog_compare),
        .tmr_src_clk(tmr_src_clk), .tmr_presc_clk(tmr_presc_clk), .opamp_enabled(opamp_enabled),
        .port_pins(port_pins), .cmp_pin_out_r(cmp_pin_out_r), .cmp_gate_r(cmp_gate_r),
        .compare_irq_r(compare_irq_r), .speed_select_r(speed_select_r),
        .hysteresis_enable_r(hysteresis_enable_r), .inputs_connect_r(inputs_connect_r),
        .plus_route_r(plus_route_r), .minus_route_r(minus_route_r),
        .minus_from_opamp_r(minus_from_opamp_r), .dir_r(dir_r));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data is looked at only in the single cycle it stands
    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_r;
    endtask : reg_read

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    // raise the result and clear the flag by a write taken at edge t after the launch
    task automatic edge_with_clear(input int t);
        @(posedge core_clk);
        analog_compare <= 1'b1;
        repeat (t - 2) @(posedge core_clk);
        reg_write(REG_FLAG, 8'h01);
        settle(8);
    endtask : edge_with_clear

    initial begin
        #(50 * 20000);
        error_cnt++;
        $display("[FAIL] watchdog expected done seen hang");
        test_done();
    end

    initial begin
        srst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        analog_compare = 1'b0;
        tmr_src_clk = 1'b0;
        tmr_presc_clk = 1'b0;
        opamp_enabled = 1'b0;
        port_pins = 8'hff;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        chk("speed_rst", 8'h01, {7'h00, speed_select_r});
        chk("dir_rst", 8'hff, dir_r);
        chk("connect_rst", 8'h00, {7'h00, inputs_connect_r});
        reg_read(REG_CTRL_A, rd); chk("ctrl_a_rst", CA_RESET, rd);
        reg_read(REG_CTRL_B, rd); chk("ctrl_b_rst", CB_RESET, rd);
        reg_read(REG_ANALOG_SELECT_REG, rd); chk("analog_select_reg_rst", 8'hff, rd);
        reg_read(REG_FLAG, rd); chk("flag_rst", 8'h00, rd);
        reg_read(4'hf, rd); chk("unmapped_rd", 8'h00, rd);
        reg_write(4'hf, 8'haa);
        reg_read(REG_CTRL_A, rd); chk("unmapped_wr", CA_RESET, rd);
        reg_write(REG_CTRL_A, 8'h40);
        reg_read(REG_CTRL_A, rd); chk("out_ro", 8'h00, rd);
        settle(2); chk("speed_low", 8'h00, {7'h00, speed_select_r});
        reg_write(REG_CTRL_A, 8'h06);
        settle(2); chk("speed_hi", 8'h01, {7'h00, speed_select_r});
        chk("hyst_on", 8'h01, {7'h00, hysteresis_enable_r});
        reg_write(REG_CTRL_A, 8'h04);
        settle(2); chk("hyst_off", 8'h00, {7'h00, hysteresis_enable_r});
        $display("test reset_regs done");

        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            analog_compare <= i[0];
            reg_write(REG_CTRL_A, {3'b100, i[1], 4'h4});
            settle(8);
            reg_read(REG_CTRL_A, rd); chk("out_state", {1'b1, i[0] ^ i[1], 1'b0, i[1], 4'h4}, rd);
            chk("gate", {7'h00, i[0] ^ i[1]}, {7'h00, cmp_gate_r});
            chk("pin_out", {7'h00, i[0] ^ i[1]}, {7'h00, cmp_pin_out_r});
        end
        $display("test polarity done");

        @(posedge core_clk);
        analog_compare <= 1'b0;
        reg_write(REG_CTRL_A, 8'h8c);
        settle(8);
        // one-cycle polarity pulse: the filter must stretch it to two cycles
        @(posedge core_clk);
        reg_addr <= REG_CTRL_A;
        reg_wdata <= 8'h9c;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wdata <= 8'h8c;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        settle(2); chk("filter_held", 8'h01, {7'h00, cmp_pin_out_r});
        settle(1); chk("filter_released", 8'h00, {7'h00, cmp_pin_out_r});
        $display("test filter done");

        reg_write(REG_CTRL_A, 8'h84);
        for (int i = 0; i < 16; i++) begin
            reg_write(REG_CTRL_B, {2'b00, 1'b0, i[3:2], 1'b0, i[1:0]});
            opamp_enabled <= i[0];
            settle(3);
            chk("plus_route", {6'h00, i[1:0]}, {5'h00, plus_route_r});
            chk("minus_route", {6'h00, i[3:2]}, {5'h00, minus_route_r});
            chk("opamp_minus", {7'h00, (i[3:2] == 2'd1) && i[0]}, {7'h00, minus_from_opamp_r});
        end
        chk("on_connect", 8'h01, {7'h00, inputs_connect_r});
        reg_write(REG_CTRL_A, 8'h04);
        settle(3);
        chk("off_plus", 8'h00, {5'h00, plus_route_r});
        chk("off_minus", 8'h00, {5'h00, minus_route_r});
        chk("off_connect", 8'h00, {7'h00, inputs_connect_r});
        $display("test routing done");

        @(posedge core_clk);
        analog_compare <= 1'b0;
        reg_write(REG_CTRL_A, 8'h84);
        reg_write(REG_CTRL_B, 8'h80);
        reg_write(REG_IRQ_EN, 8'h01);
        settle(8);
        reg_write(REG_FLAG, 8'h01);
        reg_read(REG_FLAG, rd); chk("flag_clr", 8'h00, rd);
        @(posedge core_clk);
        analog_compare <= 1'b1;
        lat = 0;
        while (compare_irq_r !== 1'b1 && lat < 20) begin
            @(posedge core_clk);
            #1;
            lat++;
        end
        chk("irq_rise", 8'h01, {7'h00, compare_irq_r});
        reg_read(REG_FLAG, rd); chk("flag_rise", 8'h01, rd);
        reg_write(REG_FLAG, 8'h01);
        @(posedge core_clk);
        analog_compare <= 1'b0;
        settle(8);
        reg_read(REG_FLAG, rd); chk("fall_masked", 8'h00, rd);
        // the flag is set at edge lat-1, so a clear taken there must lose
        edge_with_clear(lat - 1);
        reg_read(REG_FLAG, rd); chk("clear_same_cycle", 8'h01, rd);
        reg_write(REG_FLAG, 8'h01);
        @(posedge core_clk);
        analog_compare <= 1'b0;
        settle(8);
        edge_with_clear(lat);
        reg_read(REG_FLAG, rd); chk("clear_after", 8'h00, rd);
        reg_write(REG_CTRL_B, 8'h40);
        @(posedge core_clk);
        analog_compare <= 1'b0;
        settle(8);
        reg_read(REG_FLAG, rd); chk("flag_fall", 8'h01, rd);
        reg_write(REG_IRQ_EN, 8'h00);
        settle(3); chk("irq_masked", 8'h00, {7'h00, compare_irq_r});
        reg_write(REG_CTRL_A, 8'h04);
        reg_write(REG_CTRL_B, 8'h80);
        settle(8);
        reg_write(REG_FLAG, 8'h01);
        reg_write(REG_CTRL_A, 8'h14);
        settle(8);
        reg_read(REG_FLAG, rd); chk("flag_invert_off", 8'h01, rd);
        chk("pin_out_off", 8'h00, {7'h00, cmp_pin_out_r});
        $display("test interrupt done");

        reg_write(REG_CTRL_A, 8'h85);
        tmr_src_clk <= 1'b1;
        settle(8);
        @(posedge core_clk);
        tmr_src_clk <= 1'b0;
        settle(8); chk("sync_low", 8'h00, {7'h00, cmp_gate_r});
        @(posedge core_clk);
        tmr_src_clk <= 1'b1;
        analog_compare <= 1'b1;
        settle(10); chk("sync_hold", 8'h00, {7'h00, cmp_gate_r});
        @(posedge core_clk);
        tmr_src_clk <= 1'b0;
        settle(8); chk("sync_fall", 8'h01, {7'h00, cmp_gate_r});
        reg_write(REG_TMR_CTL, 8'h04);
        tmr_presc_clk <= 1'b1;
        tmr_src_clk <= 1'b1;
        analog_compare <= 1'b0;
        settle(8);
        @(posedge core_clk);
        tmr_src_clk <= 1'b0;
        settle(8); chk("presc_hold", 8'h01, {7'h00, cmp_gate_r});
        @(posedge core_clk);
        tmr_presc_clk <= 1'b0;
        settle(8); chk("presc_fall", 8'h00, {7'h00, cmp_gate_r});
        $display("test sync done");

        reg_write(REG_TMR_CTL, 8'h01);
        reg_write(REG_TMR_LO, 8'h00);
        for (int i = 0; i < 11; i++) begin
            @(posedge core_clk);
            tmr_src_clk <= ~i[0];
            settle(6);
        end
        reg_read(REG_TMR_LO, rd); chk("tmr_lo", 8'h06, rd);
        reg_read(REG_TMR_HI, rd); chk("tmr_hi", 8'h00, rd);
        // gate held low by the latched result: rising edges must not count
        reg_write(REG_TMR_CTL, 8'h03);
        reg_write(REG_TMR_LO, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            tmr_src_clk <= i[0];
            settle(6);
        end
        reg_read(REG_TMR_LO, rd); chk("tmr_gated", 8'h00, rd);
        $display("test timer done");

        reg_read(REG_PORT, rd); chk("port_all_analog", 8'h00, rd);
        reg_write(REG_ANALOG_SELECT_REG, 8'h0f);
        port_pins <= 8'h5a;
        settle(6);
        reg_read(REG_PORT, rd); chk("port_mixed", 8'h50, rd);
        reg_write(REG_DIR, 8'h3c);
        settle(2); chk("dir", 8'h3c, dir_r);
        $display("test port done");
        test_done();
    end
endmodule : tb
